/* hdl/epx_lane.sv */
`timescale 1ns/1ps
// registered lane drivers for the high isa byte and the low peripheral byte
module epx_lane (
    input  wire logic        clk_sys_in,
    input  wire logic        rst_n_in,
    epx_lane_if.lane         lanes,
    input  wire logic [7:0]  isa_data_high_byte_in,
    input  wire logic [7:0]  peripheral_data_low_byte_in,
    output logic      [7:0]  isa_data_high_byte_out,
    output logic      [7:0]  peripheral_data_low_byte_out,
    output logic             isa_data_high_byte_oe_out,
    output logic             peripheral_data_low_byte_oe_out
);

    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
        logic       oe;
    } epx_lane_s;

    epx_lane_s state;
    epx_lane_s next_state;

    always_comb begin
        next_state    = state;
        next_state.hi = lanes.drive_data[15:8];
        next_state.lo = lanes.drive_data[7:0];
        next_state.oe = lanes.drive_en;
        if (!rst_n_in) begin
            next_state = '0;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        state <= next_state;
    end

    assign lanes.lane_in = {isa_data_high_byte_in, peripheral_data_low_byte_in};
    assign isa_data_high_byte_out          = state.hi;
    assign peripheral_data_low_byte_out    = state.lo;
    assign isa_data_high_byte_oe_out       = state.oe;
    assign peripheral_data_low_byte_oe_out = state.oe;

endmodule : epx_lane

/* hdl/epx_lane_if.sv */
`timescale 1ns/1ps
// shared byte lanes between the register core and the lane driver
interface epx_lane_if;
    logic [15:0] drive_data;
    logic        drive_en;
    logic [15:0] lane_in;

    modport core (output drive_data, output drive_en, input lane_in);
    modport lane (input drive_data, input drive_en, output lane_in);
endinterface : epx_lane_if

/* hdl/epx_pkg.sv */
package epx_pkg;

    // register offsets on the plain register port
    localparam logic [7:0] ADDR_OUTPUT_LATCH = 8'h46;
    localparam logic [7:0] ADDR_INPUT_SAMPLE = 8'h48;
    localparam logic [7:0] ADDR_PIN_SELECT   = 8'h40;

    // pin select bit positions inside the configuration byte
    localparam int BIT_READ_SEL  = 6;
    localparam int BIT_WRITE_SEL = 7;

    localparam logic [15:0] RESET_OUTPUT_LATCH = 16'h0000;
    localparam logic [15:0] RESET_INPUT_SAMPLE = 16'h0000;
    localparam logic [1:0]  RESET_PIN_SELECT   = 2'h0;

    // read strobe: cycles spent in the strobe state, the strobe time rounded up to whole clocks
    localparam int READ_STROBE_TIME_NS = 200;
    localparam int CLK_PERIOD_NS       = 100;
    localparam logic [3:0] READ_STROBE_CYCLES =
        4'((READ_STROBE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum logic [1:0] {
        EPX_IDLE   = 2'h0,
        EPX_STROBE = 2'h1,
        EPX_SAMPLE = 2'h3
    } epx_state_e;

endpackage : epx_pkg

/* hdl/epx_regs.sv */
`timescale 1ns/1ps
// Operation
// - output latch is held on chip; reads return last written value
// - latch high byte drives the isa high data byte lanes
// - latch low byte drives the low peripheral data byte lanes
// - output port exists only while the write select bit is clear
// - input high byte is captured from the isa high data byte lanes
// - input low byte is captured from the low peripheral data byte lanes
// - input port exists only while the read select bit is clear; strobe active low
// - input register is read only; both registers reset to zero
// - both pin select bits live in the configuration byte at 40h
// - clear write select makes the pin the write strobe regardless of direction
module epx_regs (
    input  wire logic        clk_sys_in,
    input  wire logic        rst_n_in,
    input  wire logic [7:0]  addr_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [15:0] rdata_out,
    input  wire logic        gpio4_dir_in,
    input  wire logic        gpio4_val_in,
    input  wire logic        gpio3_dir_in,
    input  wire logic        gpio3_val_in,
    input  wire logic [7:0]  isa_data_high_byte_in,
    input  wire logic [7:0]  peripheral_data_low_byte_in,
    output logic      [7:0]  isa_data_high_byte_out,
    output logic      [7:0]  peripheral_data_low_byte_out,
    output logic             isa_data_high_byte_oe_out,
    output logic             peripheral_data_low_byte_oe_out,
    output logic             strobe_pin_out,
    output logic             strobe_pin_oe_out,
    output logic             read_pin_out,
    output logic             read_pin_oe_out,
    output logic             sample_busy_out
);

    ////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        logic [15:0]        output_expander_latch;
        logic [15:0]        input_expander_sample;
        logic               write_strobe_pin_select;
        logic               read_strobe_pin_select;
        logic [15:0]        rdata;
        logic               expander_write_strobe;
        logic               expander_read_strobe_n;
        logic               wr_pin;
        logic               wr_oe;
        logic               rd_pin;
        logic               rd_oe;
        logic               lane_en;
        logic               busy;
        logic [3:0]         count;
        epx_pkg::epx_state_e fsm;
    } epx_regs_s;

    epx_regs_s   state;
    epx_regs_s   next_state;
    epx_lane_if  lanes();

    ////////////////////////////////////////////////////////////////////////////

    always_comb begin
        next_state                       = state;
        next_state.expander_write_strobe = 1'b0;
        next_state.rdata                 = 16'h0000;
        if (rd_in) begin
            unique case (addr_in)
                epx_pkg::ADDR_OUTPUT_LATCH: next_state.rdata = state.output_expander_latch;
                epx_pkg::ADDR_INPUT_SAMPLE: next_state.rdata = state.input_expander_sample;
                epx_pkg::ADDR_PIN_SELECT: begin
                    next_state.rdata = 16'({state.write_strobe_pin_select,
                                            state.read_strobe_pin_select})
                                       << epx_pkg::BIT_READ_SEL;
                end
                default: ;
            endcase
        end
        if (wr_in && addr_in == epx_pkg::ADDR_OUTPUT_LATCH) begin
            next_state.output_expander_latch = wdata_in;
            next_state.expander_write_strobe = !state.write_strobe_pin_select;
        end
        if (wr_in && addr_in == epx_pkg::ADDR_PIN_SELECT) begin
            next_state.write_strobe_pin_select = wdata_in[epx_pkg::BIT_WRITE_SEL];
            next_state.read_strobe_pin_select  = wdata_in[epx_pkg::BIT_READ_SEL];
        end
        // writes to the input sample address fall through unheeded

        // read strobe sequence: strobe low, wait, then sample the lanes
        unique case (state.fsm)
            epx_pkg::EPX_IDLE: begin
                if (rd_in && addr_in == epx_pkg::ADDR_INPUT_SAMPLE
                        && !state.read_strobe_pin_select) begin
                    next_state.expander_read_strobe_n = 1'b0;
                    next_state.count = epx_pkg::READ_STROBE_CYCLES;
                    next_state.fsm   = epx_pkg::EPX_STROBE;
                end
            end
            epx_pkg::EPX_STROBE: begin
                next_state.count = state.count - 4'h1;
                if (state.count == 4'h1) begin
                    next_state.fsm = epx_pkg::EPX_SAMPLE;
                end
            end
            epx_pkg::EPX_SAMPLE: begin
                next_state.input_expander_sample  = lanes.lane_in;
                next_state.expander_read_strobe_n = 1'b1;
                next_state.fsm                    = epx_pkg::EPX_IDLE;
            end
            default: next_state.fsm = epx_pkg::EPX_IDLE;
        endcase

        // lanes are released while fetching input data, from one cycle after busy rises to one cycle after it falls
        next_state.busy    = (next_state.fsm != epx_pkg::EPX_IDLE);
        next_state.lane_en = !state.write_strobe_pin_select && !next_state.busy;

        // shared pins: select clear means strobe function, direction bit ignored
        if (!next_state.write_strobe_pin_select) begin
            // pin trails the lane bytes by a cycle so the latch sees settled data
            next_state.wr_pin = state.expander_write_strobe;
            next_state.wr_oe  = 1'b1;
        end else begin
            next_state.wr_pin = gpio4_val_in;
            next_state.wr_oe  = gpio4_dir_in;
        end
        if (!next_state.read_strobe_pin_select) begin
            next_state.rd_pin = next_state.expander_read_strobe_n;
            next_state.rd_oe  = 1'b1;
        end else begin
            next_state.rd_pin = gpio3_val_in;
            next_state.rd_oe  = gpio3_dir_in;
        end

        if (!rst_n_in) begin
            next_state                        = '0;
            next_state.output_expander_latch  = epx_pkg::RESET_OUTPUT_LATCH;
            next_state.input_expander_sample  = epx_pkg::RESET_INPUT_SAMPLE;
            {next_state.write_strobe_pin_select,
             next_state.read_strobe_pin_select} = epx_pkg::RESET_PIN_SELECT;
            next_state.expander_read_strobe_n = 1'b1;
            next_state.rd_pin                 = 1'b1;
            next_state.rd_oe                  = 1'b1;
            next_state.wr_oe                  = 1'b1;
            next_state.fsm                    = epx_pkg::EPX_IDLE;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        state <= next_state;
    end

    ////////////////////////////////////////////////////////////////////////////

    // lane data changes one cycle ahead of the write strobe pulse, giving setup
    assign lanes.drive_data = next_state.output_expander_latch;
    assign lanes.drive_en   = state.lane_en;

    epx_lane u_lane (
        .clk_sys_in                      (clk_sys_in),
        .rst_n_in                        (rst_n_in),
        .lanes                           (lanes.lane),
        .isa_data_high_byte_in           (isa_data_high_byte_in),
        .peripheral_data_low_byte_in     (peripheral_data_low_byte_in),
        .isa_data_high_byte_out          (isa_data_high_byte_out),
        .peripheral_data_low_byte_out    (peripheral_data_low_byte_out),
        .isa_data_high_byte_oe_out       (isa_data_high_byte_oe_out),
        .peripheral_data_low_byte_oe_out (peripheral_data_low_byte_oe_out)
    );

    assign rdata_out         = state.rdata;
    assign strobe_pin_out    = state.wr_pin;
    assign strobe_pin_oe_out = state.wr_oe;
    assign read_pin_out      = state.rd_pin;
    assign read_pin_oe_out   = state.rd_oe;
    assign sample_busy_out   = state.busy;

endmodule : epx_regs

/* verification/epx_ext_model.sv */
`timescale 1ns/1ps
module epx_ext_model (
    input  wire logic        clk_sys_in,
    input  wire logic        we_in,
    input  wire logic        re_n_in,
    input  wire logic [15:0] drv_in,
    input  wire logic [1:0]  oe_in,
    input  wire logic [15:0] pattern_in,
    output logic      [15:0] lane_out,
    output logic      [15:0] latch_out
);
    logic [15:0] last = 16'h0000;
    initial latch_out = 16'h0000;
    always @(posedge clk_sys_in) begin
        if (we_in)
            latch_out <= lane_out;
        last <= lane_out;
    end
    // nobody driving: lanes flip every cycle so stale data never passes
    always_comb begin
        lane_out = ~last;
        if (!re_n_in)
            lane_out = pattern_in;
        if (oe_in[1])
            lane_out[15:8] = drv_in[15:8];
        if (oe_in[0])
            lane_out[7:0] = drv_in[7:0];
    end
endmodule : epx_ext_model

/* verification/epx_regs_chk.sv */
`timescale 1ns/1ps
module epx_regs_chk (
    input wire logic        clk_sys_in,
    input wire logic        rst_n_in,
    input wire logic [7:0]  addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic [15:0] rdata_out,
    input wire logic        gpio4_val_in,
    input wire logic [7:0]  isa_data_high_byte_out,
    input wire logic [7:0]  peripheral_data_low_byte_out,
    input wire logic        isa_data_high_byte_oe_out,
    input wire logic        peripheral_data_low_byte_oe_out,
    input wire logic        strobe_pin_out,
    input wire logic        strobe_pin_oe_out,
    input wire logic        read_pin_out,
    input wire logic        read_pin_oe_out,
    input wire logic        sample_busy_out
);
    logic [1:0]  sel;
    logic [15:0] lat;
    logic        w46;
    logic        r48;
    assign w46 = wr_in && addr_in == epx_pkg::ADDR_OUTPUT_LATCH;
    assign r48 = rd_in && addr_in == epx_pkg::ADDR_INPUT_SAMPLE;
    // shadow copies so the checks need no view inside the block
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            sel <= 2'h0;
            lat <= 16'h0000;
        end else begin
            if (wr_in && addr_in == epx_pkg::ADDR_PIN_SELECT)
                sel <= {wdata_in[epx_pkg::BIT_WRITE_SEL], wdata_in[epx_pkg::BIT_READ_SEL]};
            if (w46)
                lat <= wdata_in;
        end
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    latch_readback_a: assert property (
        rd_in && addr_in == epx_pkg::ADDR_OUTPUT_LATCH |=> rdata_out == $past(lat)
    ) else $error("latch readback differs from last write");
    lane_bytes_a: assert property (
        w46 && !sample_busy_out |=>
            {isa_data_high_byte_out, peripheral_data_low_byte_out} == $past(wdata_in)
    ) else $error("lane bytes do not carry the written latch");
    write_pulse_a: assert property (
        w46 && !sel[1] ##1 !w46 |=> strobe_pin_out ##1 !strobe_pin_out
    ) else $error("write strobe is not a single pulse");
    no_stray_pulse_a: assert property (
        strobe_pin_out && !sel[1] && !$past(sel[1]) |-> $past(w46, 2)
    ) else $error("write strobe without a latch write");
    strobe_drive_a: assert property (
        !sel[1] |-> strobe_pin_oe_out
    ) else $error("write strobe pin not driven");
    read_drive_a: assert property (
        !sel[0] |-> read_pin_oe_out
    ) else $error("read strobe pin not driven");
    gpio_mode_a: assert property (
        sel[1] && $past(sel[1]) |-> strobe_pin_out == $past(gpio4_val_in)
    ) else $error("pin does not follow its general purpose value");
    read_strobe_a: assert property (
        r48 && !sel[0] && !sample_busy_out |=> !read_pin_out [*3] ##1 read_pin_out
    ) else $error("read strobe not low for three cycles");
    lane_release_a: assert property (
        r48 && !sel[0] && !sample_busy_out |=> ##1
            !(isa_data_high_byte_oe_out || peripheral_data_low_byte_oe_out) [*3]
    ) else $error("lanes still driven while buffers drive them");
    quiet_rdata_a: assert property (
        !(rd_in && (addr_in == epx_pkg::ADDR_PIN_SELECT
            || addr_in == epx_pkg::ADDR_OUTPUT_LATCH || addr_in == epx_pkg::ADDR_INPUT_SAMPLE))
            |=> rdata_out == 16'h0000
    ) else $error("read data not zero outside a mapped read");
endmodule : epx_regs_chk

bind epx_regs epx_regs_chk chk (.clk_sys_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .gpio4_val_in, .isa_data_high_byte_out, .peripheral_data_low_byte_out,
    .isa_data_high_byte_oe_out, .peripheral_data_low_byte_oe_out,
    .strobe_pin_out, .strobe_pin_oe_out, .read_pin_out, .read_pin_oe_out, .sample_busy_out);

/* verification/external_port_expander_regs_tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin \
    $display("[ERR] %s exp %h got %h", n, e, a); n_fail++; end end
module external_port_expander_regs_tb;
    logic        clk_sys_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic [7:0]  addr_in = 8'h00;
    logic        wr_in = 1'b0;
    logic        rd_in = 1'b0;
    logic [15:0] wdata_in = 16'h0000, pat = 16'h0000, g = 16'h0060, seed = 16'h0060;
    logic [15:0] rdata_out, lane, latch, v, old;
    logic [7:0]  isa_data_high_byte_out, peripheral_data_low_byte_out;
    logic        isa_data_high_byte_oe_out, peripheral_data_low_byte_oe_out;
    logic        strobe_pin_out, strobe_pin_oe_out, read_pin_out, read_pin_oe_out, sample_busy_out;
    int          n_fail = 0, checks_done = 0;
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr
    always #50 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) g <= lfsr(g);
    epx_regs dut (.clk_sys_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
        .gpio4_dir_in(g[0]), .gpio4_val_in(g[1]), .gpio3_dir_in(g[2]), .gpio3_val_in(g[3]),
        .isa_data_high_byte_in(lane[15:8]), .peripheral_data_low_byte_in(lane[7:0]),
        .isa_data_high_byte_out, .peripheral_data_low_byte_out, .isa_data_high_byte_oe_out,
        .peripheral_data_low_byte_oe_out, .strobe_pin_out, .strobe_pin_oe_out, .read_pin_out,
        .read_pin_oe_out, .sample_busy_out);
    epx_ext_model ext (.clk_sys_in, .we_in(strobe_pin_out), .re_n_in(read_pin_out),
        .drv_in({isa_data_high_byte_out, peripheral_data_low_byte_out}),
        .oe_in({isa_data_high_byte_oe_out, peripheral_data_low_byte_oe_out}),
        .pattern_in(pat), .lane_out(lane), .latch_out(latch));
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_sys_in);
        wr_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_sys_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_sys_in);
        rd_in <= 1'b0;
        @(negedge clk_sys_in);
        d = rdata_out;
    endtask : rd
    task automatic wait_idle();
        int i;
        for (i = 0; i < 20 && sample_busy_out !== 1'b0; i++)
            @(posedge clk_sys_in);
        if (i == 20) begin
            n_fail++;
            results();
        end
    endtask : wait_idle
    initial begin
        repeat (4) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        rd(epx_pkg::ADDR_OUTPUT_LATCH, v); `CHK("latch reset", 16'h0000, v)
        wr(epx_pkg::ADDR_INPUT_SAMPLE, 16'hA5C3);
        rd(epx_pkg::ADDR_INPUT_SAMPLE, v); `CHK("sample reset", 16'h0000, v)
        rd(8'h4A, v); `CHK("unmapped", 16'h0000, v)
        for (int k = 0; k < 6; k++) begin
            seed = lfsr(seed);
            old = (k == 0) ? 16'hFFFF : seed;
            wr(epx_pkg::ADDR_OUTPUT_LATCH, old);
            rd(epx_pkg::ADDR_OUTPUT_LATCH, v); `CHK("latch read", old, v)
            `CHK("ext latch", old, latch)
        end
        for (int k = 0; k < 3; k++) begin
            seed = lfsr(seed);
            pat <= seed;
            rd(epx_pkg::ADDR_INPUT_SAMPLE, v);
            wait_idle();
            rd(epx_pkg::ADDR_INPUT_SAMPLE, v); `CHK("sample", seed, v)
            wait_idle();
        end
        wr(epx_pkg::ADDR_PIN_SELECT, 16'h00C0);
        rd(epx_pkg::ADDR_PIN_SELECT, v); `CHK("select", 16'h00C0, v)
        pat <= ~seed;
        `CHK("lane oe gpio", 1'b0, isa_data_high_byte_oe_out)
        wr(epx_pkg::ADDR_OUTPUT_LATCH, 16'h0000);
        rd(epx_pkg::ADDR_INPUT_SAMPLE, v);
        wait_idle();
        rd(epx_pkg::ADDR_INPUT_SAMPLE, v); `CHK("no strobe sample", seed, v)
        repeat (8) @(posedge clk_sys_in);
        wr(epx_pkg::ADDR_PIN_SELECT, 16'h0000);
        wr(epx_pkg::ADDR_OUTPUT_LATCH, 16'h8001);
        rd(epx_pkg::ADDR_OUTPUT_LATCH, v); `CHK("latch back", 16'h8001, latch)
        // second reset in mid-run: both expander registers must return to zero
        @(posedge clk_sys_in);
        rst_n_in <= 1'b0;
        repeat (4) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        rd(epx_pkg::ADDR_OUTPUT_LATCH, v); `CHK("latch rerst", 16'h0000, v)
        rd(epx_pkg::ADDR_INPUT_SAMPLE, v); `CHK("sample rerst", 16'h0000, v)
        results();
    end
endmodule : external_port_expander_regs_tb
